// *** adcr_top.sv ***
// Purpose: Converter control registers and sequencing toward the analog macro
// Assumes: Register port with address, write strobe, read strobe, 32-bit data
// Notes:   Read data is registered; answer appears one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module adcr_top #(
   parameter int unsigned FIFO_DEPTH = 4,
   parameter int unsigned RES_W      = 12
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // Register port
   input  wire logic [5:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [31:0]       reg_wdata,
   output logic [31:0]            reg_rdata,
   // Converter macro
   output logic [3:0]             input_channel_select,
   output logic [2:0]             sample_timing_ctrl,
   output logic                   analog_powerdown,
   output logic                   bias_powerdown,
   output logic                   conv_clk_gate,
   output logic                   conv_start,
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_result,
   // Interrupt requests, gated by the enables
   output logic                   dv_irq,
   output logic                   ov_irq,
   // DMA path
   output logic                   dma_req,
   output logic [RES_W-1:0]       dma_data,
   input  wire logic              dma_ack
);
   // Registers
   logic [2:0]       mode_ff;       // Mode enables
   logic             start_ff;      // Start request bit
   logic [6:0]       cfg_ff;        // Channel and timing
   logic [1:0]       pwr_ff;        // Power down bits
   logic [11:0]      cnt_ff;        // DMA sample count
   logic [1:0]       ien_ff;        // Interrupt enables
   logic             dvst_ff;       // Data-valid event seen
   logic             ovst_ff;       // Overflow event seen
   logic             busy_ff;       // Conversion in progress
   logic             cgate_ff;      // Converter clock gate
   logic [11:0]      done_ff;       // Samples converted in DMA run
   logic             start_q_ff;    // Start bit delayed, edge sense
   logic             conv_start_ff; // Start pulse to macro
   logic [31:0]      rdata_ff;      // Read answer
   logic             dv_irq_ff;
   logic             ov_irq_ff;
   logic             dma_req_ff;
   logic [RES_W-1:0] dma_data_ff;
   // Combinational
   logic             wr_start;
   logic             go;
   logic             dma_full;
   logic             flush;
   logic             fifo_pop;
   logic             fifo_ovf;
   logic             fifo_empty;
   logic [RES_W-1:0] fifo_q;
   logic [2:0]       nxt_mode;

   // Write decode shared by several registers
   function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
      return a == off;
   endfunction

   assign wr_start = reg_wr && hit(reg_addr, adcr_pkg::OFF_START);
   assign nxt_mode = reg_wdata[2:0];
   // Any enable going from one to zero empties the result FIFO
   assign flush    = reg_wr && hit(reg_addr, adcr_pkg::OFF_MODE)
                     && |(mode_ff & ~nxt_mode);
   assign dma_full = (done_ff >= cnt_ff);

   // Start decision per mode
   always_comb begin
      go = 1'b0;
      if (!busy_ff && !cgate_ff) begin
         if (mode_ff[adcr_pkg::MODE_ONE_BIT]) begin
            go = start_ff && !start_q_ff;
         end else if (mode_ff[adcr_pkg::MODE_DMA_BIT]) begin
            // The edge opens a run; later starts follow while samples remain,
            // so one write of the start bit converts the whole programmed count
            go = start_ff && (!start_q_ff || done_ff != 12'h000) && !dma_full;
         end else if (mode_ff[adcr_pkg::MODE_FREE_BIT]) begin
            go = start_ff;
         end
      end
   end

   // Mode register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_ff <= '0;
      end else if (reg_wr && hit(reg_addr, adcr_pkg::OFF_MODE)) begin
         mode_ff <= nxt_mode;
      end
   end

   // Start bit and its delayed copy for edge sensing
   always_ff @(posedge core_clk) begin
      if (srst) begin
         start_ff   <= 1'b0;
         start_q_ff <= 1'b0;
      end else begin
         if (wr_start) begin
            start_ff <= reg_wdata[0];
         end
         start_q_ff <= start_ff;
      end
   end

   // Configuration, power, count, enables, clock gate
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_ff   <= '0;
         pwr_ff   <= adcr_pkg::RST_PWR;
         cnt_ff   <= adcr_pkg::RST_CNT;
         ien_ff   <= '0;
         cgate_ff <= adcr_pkg::RST_CGATE;
      end else if (reg_wr) begin
         if (hit(reg_addr, adcr_pkg::OFF_CFG)) begin
            cfg_ff <= reg_wdata[6:0];
         end
         if (hit(reg_addr, adcr_pkg::OFF_PWR)) begin
            pwr_ff <= reg_wdata[1:0];
         end
         if (hit(reg_addr, adcr_pkg::OFF_CNT)) begin
            cnt_ff <= reg_wdata[11:0];
         end
         if (hit(reg_addr, adcr_pkg::OFF_IEN)) begin
            ien_ff <= reg_wdata[1:0];
         end
         if (hit(reg_addr, adcr_pkg::OFF_CGATE)) begin
            cgate_ff <= reg_wdata[0];
         end
      end
   end

   // Busy tracking and start pulse; DMA stops at count
   always_ff @(posedge core_clk) begin
      if (srst) begin
         busy_ff       <= 1'b0;
         conv_start_ff <= 1'b0;
      end else begin
         conv_start_ff <= go && !(mode_ff[adcr_pkg::MODE_DMA_BIT] && dma_full);
         if (go && !(mode_ff[adcr_pkg::MODE_DMA_BIT] && dma_full)) begin
            busy_ff <= 1'b1;
         end else if (conv_done) begin
            busy_ff <= 1'b0;
         end
      end
   end

   // DMA sample counter; restarts on each new start edge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         done_ff <= '0;
      end else if (wr_start && reg_wdata[0] && !start_ff) begin
         done_ff <= '0;
      end else if (conv_done && mode_ff[adcr_pkg::MODE_DMA_BIT] && !dma_full) begin
         done_ff <= done_ff + 12'h001;
      end
   end

   // Sticky event flags; a new event outranks clearing by a flush
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dvst_ff <= 1'b0;
         ovst_ff <= 1'b0;
      end else begin
         if (conv_done) begin
            dvst_ff <= 1'b1;
         end else if (flush) begin
            dvst_ff <= 1'b0;
         end
         if (fifo_ovf) begin
            ovst_ff <= 1'b1;
         end else if (flush) begin
            ovst_ff <= 1'b0;
         end
      end
   end

   // Interrupt outputs gated by enables
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dv_irq_ff <= 1'b0;
         ov_irq_ff <= 1'b0;
      end else begin
         dv_irq_ff <= dvst_ff && ien_ff[adcr_pkg::IEN_DV_BIT];
         ov_irq_ff <= ovst_ff && ien_ff[adcr_pkg::IEN_OV_BIT];
      end
   end

   // DMA handoff: present head of FIFO until acknowledged
   always_ff @(posedge core_clk) begin
      if (srst || flush) begin
         dma_req_ff  <= 1'b0;
         dma_data_ff <= '0;
      end else if (dma_req_ff) begin
         if (dma_ack) begin
            dma_req_ff <= 1'b0;
         end
      end else if (mode_ff[adcr_pkg::MODE_DMA_BIT] && !fifo_empty) begin
         dma_req_ff  <= 1'b1;
         dma_data_ff <= fifo_q;
      end
   end

   // Read pops the FIFO in CPU modes, DMA takes it otherwise
   assign fifo_pop = mode_ff[adcr_pkg::MODE_DMA_BIT]
                     ? (!dma_req_ff && !fifo_empty)
                     : (reg_rd && hit(reg_addr, adcr_pkg::OFF_DATA));

   // Result FIFO
   adcr_fifo #(
      .WIDTH (RES_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .srst     (srst),
      .flush    (flush),
      .push     (conv_done),
      .wdata    (conv_result),
      .ovf      (fifo_ovf),
      .pop      (fifo_pop),
      .rdata    (fifo_q),
      .empty    (fifo_empty)
   );

   // Read mux, registered; unmapped reads as zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_ff <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            adcr_pkg::OFF_DATA:  rdata_ff <= {20'h0, fifo_empty ? 12'h000 : fifo_q};
            adcr_pkg::OFF_MODE:  rdata_ff <= {29'h0, mode_ff};
            adcr_pkg::OFF_START: rdata_ff <= {31'h0, start_ff};
            adcr_pkg::OFF_CFG:   rdata_ff <= {25'h0, cfg_ff};
            adcr_pkg::OFF_PWR:   rdata_ff <= {30'h0, pwr_ff};
            adcr_pkg::OFF_CNT:   rdata_ff <= {20'h0, cnt_ff};
            adcr_pkg::OFF_IEN:   rdata_ff <= {30'h0, ien_ff};
            adcr_pkg::OFF_DVST:  rdata_ff <= {31'h0, dvst_ff};
            adcr_pkg::OFF_OVST:  rdata_ff <= {31'h0, ovst_ff};
            adcr_pkg::OFF_BUSY:  rdata_ff <= {31'h0, busy_ff};
            adcr_pkg::OFF_CGATE: rdata_ff <= {31'h0, cgate_ff};
            default:             rdata_ff <= '0;
         endcase
      end
   end

   // Outputs, all from flip-flops
   assign reg_rdata            = rdata_ff;
   assign input_channel_select = cfg_ff[adcr_pkg::CH_MSB:adcr_pkg::CH_LSB];
   assign sample_timing_ctrl   = cfg_ff[adcr_pkg::TM_MSB:adcr_pkg::TM_LSB];
   assign analog_powerdown     = pwr_ff[adcr_pkg::PWR_ANA_BIT];
   assign bias_powerdown       = pwr_ff[adcr_pkg::PWR_BIAS_BIT];
   assign conv_clk_gate        = cgate_ff;
   assign conv_start           = conv_start_ff;
   assign dv_irq               = dv_irq_ff;
   assign ov_irq               = ov_irq_ff;
   assign dma_req              = dma_req_ff;
   assign dma_data             = dma_data_ff;

   // Assertions
   // Reset values seen on the first edge after release
   a_pwr_reset: assert property (@(posedge core_clk)
      $fell(srst) |-> analog_powerdown && bias_powerdown)
      else $error("power bits not set after reset");
   a_gate_reset: assert property (@(posedge core_clk)
      $fell(srst) |-> conv_clk_gate)
      else $error("clock gate not set after reset");
   a_cnt_reset: assert property (@(posedge core_clk)
      $fell(srst) |-> cnt_ff == 12'h001)
      else $error("sample count reset wrong");
   // Register writes reach the flops and the macro pins one edge later
   a_mode_write: assert property (@(posedge core_clk) disable iff (srst)
      reg_wr && reg_addr == adcr_pkg::OFF_MODE |=> mode_ff == $past(reg_wdata[2:0]))
      else $error("mode register not written");
   a_start_write: assert property (@(posedge core_clk) disable iff (srst)
      reg_wr && reg_addr == adcr_pkg::OFF_START |=> start_ff == $past(reg_wdata[0]))
      else $error("start bit not written");
   a_cfg_pass: assert property (@(posedge core_clk) disable iff (srst)
      reg_wr && reg_addr == adcr_pkg::OFF_CFG
      |=> input_channel_select == $past(reg_wdata[3:0])
          && sample_timing_ctrl == $past(reg_wdata[6:4]))
      else $error("config not passed to macro");
   a_pwr_write: assert property (@(posedge core_clk) disable iff (srst)
      reg_wr && reg_addr == adcr_pkg::OFF_PWR
      |=> analog_powerdown == $past(reg_wdata[0]) && bias_powerdown == $past(reg_wdata[1]))
      else $error("power bits not written");
   a_gate_write: assert property (@(posedge core_clk) disable iff (srst)
      reg_wr && reg_addr == adcr_pkg::OFF_CGATE |=> conv_clk_gate == $past(reg_wdata[0]))
      else $error("clock gate not written");
   // Conversion sequencing toward the macro
   a_busy_start: assert property (@(posedge core_clk) disable iff (srst)
      conv_start |-> busy_ff)
      else $error("start without busy");
   a_busy_clear: assert property (@(posedge core_clk) disable iff (srst)
      $fell(busy_ff) |-> $past(conv_done))
      else $error("busy dropped without completion");
   a_gate_start: assert property (@(posedge core_clk) disable iff (srst)
      conv_start |-> !$past(conv_clk_gate))
      else $error("start while converter clock stopped");
   a_one_edge: assert property (@(posedge core_clk) disable iff (srst)
      conv_start && mode_ff == 3'h1 |-> $past(start_ff) && !$past(start_q_ff))
      else $error("single mode start not on edge");
   a_free_level: assert property (@(posedge core_clk) disable iff (srst)
      mode_ff == 3'h2 && start_ff && !busy_ff && !cgate_ff |=> conv_start)
      else $error("free-running start level ignored");
   a_dma_stop: assert property (@(posedge core_clk) disable iff (srst)
      mode_ff == 3'h4 && dma_full |-> !conv_start_ff ##1 !conv_start)
      else $error("dma run passed sample count");
   // Interrupt gating and sticky events
   a_dv_irq: assert property (@(posedge core_clk) disable iff (srst)
      dv_irq |-> $past(dvst_ff) && $past(ien_ff[0]))
      else $error("data-valid irq not gated");
   a_ov_irq: assert property (@(posedge core_clk) disable iff (srst)
      ov_irq |-> $past(ovst_ff) && $past(ien_ff[1]))
      else $error("overflow irq not gated");
   a_dv_sticky: assert property (@(posedge core_clk) disable iff (srst)
      conv_done |=> dvst_ff)
      else $error("data-valid event lost");
   a_ov_sticky: assert property (@(posedge core_clk) disable iff (srst)
      fifo_ovf |=> ovst_ff)
      else $error("overflow event lost");
   // Result queue: flush on mode clear, reads take the head
   a_flush_empty: assert property (@(posedge core_clk) disable iff (srst)
      flush |=> fifo_empty)
      else $error("mode clear left results queued");
   a_flush_clear: assert property (@(posedge core_clk) disable iff (srst)
      flush && !conv_done && !fifo_ovf |=> !dvst_ff && !ovst_ff)
      else $error("mode clear left events set");
   a_rd_data: assert property (@(posedge core_clk) disable iff (srst)
      reg_rd && reg_addr == adcr_pkg::OFF_DATA && !fifo_empty
      |=> reg_rdata == {20'h0, $past(fifo_q)})
      else $error("data read not from queue head");
endmodule : adcr_top
`default_nettype wire

// *** adcr_pkg.sv ***
// Purpose: Constants for the converter control register block
// Assumes: 32-bit register words on a peripheral-style port, byte offsets
// Notes:   Offsets, field positions and reset values live here only
package adcr_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam logic [5:0] OFF_DATA   = 6'h04;  // Result word read
   localparam logic [5:0] OFF_MODE   = 6'h0C;  // Mode select
   localparam logic [5:0] OFF_START  = 6'h10;  // Conversion start
   localparam logic [5:0] OFF_CFG    = 6'h14;  // Channel and timing
   localparam logic [5:0] OFF_PWR    = 6'h18;  // Power down control
   localparam logic [5:0] OFF_CNT    = 6'h1C;  // DMA sample count
   localparam logic [5:0] OFF_IEN    = 6'h20;  // Interrupt enables
   localparam logic [5:0] OFF_DVST   = 6'h24;  // Data-valid status
   localparam logic [5:0] OFF_OVST   = 6'h28;  // Overflow status
   localparam logic [5:0] OFF_BUSY   = 6'h2C;  // Busy flag
   localparam logic [5:0] OFF_CGATE  = 6'h30;  // Clock gate
   localparam int unsigned MODE_ONE_BIT  = 0;
   localparam int unsigned MODE_FREE_BIT = 1;
   localparam int unsigned MODE_DMA_BIT  = 2;
   localparam int unsigned CH_LSB = 0;
   localparam int unsigned CH_MSB = 3;
   localparam int unsigned TM_LSB = 4;
   localparam int unsigned TM_MSB = 6;
   localparam int unsigned PWR_ANA_BIT  = 0;
   localparam int unsigned PWR_BIAS_BIT = 1;
   localparam int unsigned IEN_DV_BIT = 0;
   localparam int unsigned IEN_OV_BIT = 1;
   localparam logic [1:0]  RST_PWR   = 2'h3;
   localparam logic [11:0] RST_CNT   = 12'h001;
   localparam logic        RST_CGATE = 1'h1;
endpackage : adcr_pkg

// *** adcr_fifo.sv ***
// Purpose: Small result FIFO between converter and data register
// Assumes: Single clock, synchronous high reset
// Notes:   A push into a full FIFO is dropped and reported as overflow
`timescale 1ns/1ps
`default_nettype none
module adcr_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             srst,
   // Control
   input  wire logic             flush,
   // Write side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   output logic                  ovf,
   // Read side
   input  wire logic             pop,
   output logic [WIDTH-1:0]      rdata,
   output logic                  empty
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage, flip-flops
   logic [AW-1:0]    wr_ff;            // Write index
   logic [AW-1:0]    rd_ff;            // Read index
   logic [AW:0]      cnt_ff;           // Fill level
   logic             full;
   logic             do_push;
   logic             do_pop;

   assign full    = (cnt_ff == (AW+1)'(DEPTH));
   assign empty   = (cnt_ff == '0);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign ovf     = push && full;
   assign rdata   = mem_ff[rd_ff];

   // Pointer and level bookkeeping; flush wins over traffic
   always_ff @(posedge core_clk) begin
      if (srst || flush) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Storage write
   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem_ff[wr_ff] <= wdata;
      end
   end
endmodule : adcr_fifo
`default_nettype wire

// *** adcr_conv_model.sv ***
// Purpose: Behavioural converter macro and DMA taker facing the control block
// Assumes: Drives its outputs on the falling edge, like the rest of the bench
// Notes:   Result k after reset is BASE plus k; bus shows inverse when idle
`timescale 1ns/1ps
`default_nettype none
module adcr_conv_model #(
   parameter int unsigned LAT     = 8,       // Conversion time in cycles
   parameter logic [11:0] BASE    = 12'h100, // First result value
   parameter int unsigned ACK_DLY = 3        // Cycles before a DMA word is taken
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Converter side
   input  wire logic        conv_start,
   input  wire logic        conv_clk_gate,
   output logic             conv_done,
   output logic [11:0]      conv_result,
   // DMA side
   input  wire logic        dma_req,
   output logic             dma_ack
);
   int          busy_cnt = 0;        // Cycles left in the running conversion
   int          ack_cnt  = 0;        // Cycles the current DMA request has waited
   int          n        = 0;        // Conversions finished since reset
   logic        done_r   = 1'b0;     // One-cycle completion pulse
   logic        ack_r    = 1'b0;     // One-cycle DMA take pulse
   logic [11:0] val      = 12'h000;  // Last result
   // Outside the done pulse the result bus is not held, so show the inverse
   assign conv_result = done_r ? val : ~val;
   assign conv_done   = done_r;
   assign dma_ack     = ack_r;
   // Conversion timer and DMA taker
   always @(negedge core_clk) begin
      if (srst) begin
         busy_cnt <= 0;
         ack_cnt  <= 0;
         n        <= 0;
         done_r   <= 1'b0;
         ack_r    <= 1'b0;
      end else begin
         done_r <= (busy_cnt == 1);
         if (busy_cnt == 1) begin
            val <= BASE + 12'(n);
            n   <= n + 1;
         end
         // A stopped converter clock means no new conversion starts
         if (conv_start && !conv_clk_gate) begin
            busy_cnt <= LAT;
         end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
         end
         // Take a word only after a deliberate stall
         if (dma_req && ack_cnt == ACK_DLY) begin
            ack_r   <= 1'b1;
            ack_cnt <= 0;
         end else begin
            ack_r   <= 1'b0;
            ack_cnt <= dma_req ? ack_cnt + 1 : 0;
         end
      end
   end
endmodule // adcr_conv_model
`default_nettype wire

// *** adcr_tb.sv ***
// Purpose: Self-checking bench for the converter control registers
// Assumes: Inputs change on the falling edge; reads answer one cycle later
// Notes:   Expected results follow the model's BASE plus conversion index
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        core_clk;              // 25 MHz clock
   logic        srst;                  // Sync reset, high
   logic [5:0]  reg_addr;              // Register port
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic [3:0]  input_channel_select;  // Converter controls
   logic [2:0]  sample_timing_ctrl;
   logic        analog_powerdown;
   logic        bias_powerdown;
   logic        conv_clk_gate;
   logic        conv_start;
   logic        conv_done;
   logic [11:0] conv_result;
   logic        dv_irq;                // Gated interrupts
   logic        ov_irq;
   logic        dma_req;               // DMA path
   logic [11:0] dma_data;
   logic        dma_ack;
   int          num_errors;            // Mismatches seen
   int          compares;              // Comparisons made
   int          starts;                // Conversion start pulses seen
   int          dones;                 // Completions seen
   int          dma_n;                 // DMA words taken
   int          dma_base;              // Conversion index of first DMA word
   int          snap;                  // Saved count
   adcr_top adcr_top_i (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .input_channel_select(input_channel_select), .sample_timing_ctrl(sample_timing_ctrl),
      .analog_powerdown(analog_powerdown), .bias_powerdown(bias_powerdown),
      .conv_clk_gate(conv_clk_gate), .conv_start(conv_start), .conv_done(conv_done),
      .conv_result(conv_result), .dv_irq(dv_irq), .ov_irq(ov_irq), .dma_req(dma_req),
      .dma_data(dma_data), .dma_ack(dma_ack));
   adcr_conv_model adcr_conv_model_i (.core_clk(core_clk), .srst(srst),
      .conv_start(conv_start), .conv_clk_gate(conv_clk_gate), .conv_done(conv_done),
      .conv_result(conv_result), .dma_req(dma_req), .dma_ack(dma_ack));
   // Free-running clock
   always #20 core_clk = ~core_clk;
   // Event counters used by the waits
   always @(posedge core_clk) begin
      if (conv_start === 1'b1) begin
         starts++;
      end
      if (conv_done === 1'b1) begin
         dones++;
      end
   end
   // Every DMA word must carry results in conversion order
   always @(posedge core_clk) begin
      if (dma_req === 1'b1 && dma_ack === 1'b1) begin
         chk(32'(dma_data), 32'(12'h100 + 12'(dma_base + dma_n)), "dma word");
         dma_n++;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
      end
   endtask
   // One-cycle write strobe, held across the sampling edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   // Read strobe, answer taken once it has been registered
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string msg);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp, msg);
   endtask
   // Bounded wait for a counter to reach a target
   task automatic wait_cnt(ref int c, input int tgt);
      int i;
      i = 0;
      while (c < tgt && i < 300) begin
         @(negedge core_clk);
         i++;
      end
      chk(32'(c >= tgt), 32'h1, "wait count");
   endtask
   task automatic finish_test();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run of about five hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      reg_addr = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0;
      {num_errors, compares, starts, dones, dma_n, dma_base} = '0;
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      // Reset values and an unmapped place
      rdc(adcr_pkg::OFF_PWR, 32'h3, "pwr reset");
      rdc(adcr_pkg::OFF_CNT, 32'h1, "count reset");
      rdc(adcr_pkg::OFF_CGATE, 32'h1, "gate reset");
      rdc(adcr_pkg::OFF_MODE, 32'h0, "mode reset");
      rdc(6'h3C, 32'h0, "unmapped");
      chk(32'({analog_powerdown, bias_powerdown, conv_clk_gate}), 32'h7, "pins");
      // Channel and timing pass straight through
      wr(adcr_pkg::OFF_CFG, 32'h0000_005A);
      chk(32'(input_channel_select), 32'hA, "channel");
      chk(32'(sample_timing_ctrl), 32'h5, "timing");
      rdc(adcr_pkg::OFF_CFG, 32'h0000_005A, "cfg back");
      wr(adcr_pkg::OFF_PWR, 32'h2);
      chk(32'({analog_powerdown, bias_powerdown}), 32'h1, "analog on");
      wr(adcr_pkg::OFF_PWR, 32'h0);
      chk(32'({analog_powerdown, bias_powerdown}), 32'h0, "all on");
      wr(adcr_pkg::OFF_CNT, 32'h0000_0FFF);
      rdc(adcr_pkg::OFF_CNT, 32'h0000_0FFF, "count full");
      // A start while the converter clock is stopped goes nowhere
      wr(adcr_pkg::OFF_MODE, 32'h1);
      wr(adcr_pkg::OFF_START, 32'h0);
      wr(adcr_pkg::OFF_START, 32'h1);
      repeat (20) @(negedge core_clk);
      chk(32'(starts), 32'h0, "gated start");
      wr(adcr_pkg::OFF_START, 32'h0);
      wr(adcr_pkg::OFF_CGATE, 32'h0);
      chk(32'(conv_clk_gate), 32'h0, "gate off");
      // Single conversion on a rising start
      wr(adcr_pkg::OFF_START, 32'h1);
      wait_cnt(starts, 1);
      rdc(adcr_pkg::OFF_BUSY, 32'h1, "busy");
      wait_cnt(dones, 1);
      repeat (2) @(negedge core_clk);
      rdc(adcr_pkg::OFF_BUSY, 32'h0, "idle");
      rdc(adcr_pkg::OFF_DVST, 32'h1, "dv status");
      chk(32'(dv_irq), 32'h0, "dv masked");
      wr(adcr_pkg::OFF_IEN, 32'h1);
      repeat (2) @(negedge core_clk);
      chk(32'(dv_irq), 32'h1, "dv irq");
      rdc(adcr_pkg::OFF_DATA, 32'h100, "result");
      repeat (30) @(negedge core_clk);
      chk(32'(starts), 32'h1, "held level");
      // Five more results into a four-deep queue
      for (int k = 2; k <= 6; k++) begin
         wr(adcr_pkg::OFF_START, 32'h0);
         wr(adcr_pkg::OFF_START, 32'h1);
         wait_cnt(dones, k);
      end
      repeat (3) @(negedge core_clk);
      rdc(adcr_pkg::OFF_OVST, 32'h1, "ov status");
      chk(32'(ov_irq), 32'h0, "ov masked");
      wr(adcr_pkg::OFF_IEN, 32'h3);
      repeat (2) @(negedge core_clk);
      chk(32'(ov_irq), 32'h1, "ov irq");
      rdc(adcr_pkg::OFF_DATA, 32'h101, "oldest");
      // Leaving the mode empties the queue and its events
      wr(adcr_pkg::OFF_MODE, 32'h0);
      rdc(adcr_pkg::OFF_DATA, 32'h0, "flushed");
      rdc(adcr_pkg::OFF_DVST, 32'h0, "dv cleared");
      rdc(adcr_pkg::OFF_OVST, 32'h0, "ov cleared");
      // Free-running restarts while the start level stays high
      wr(adcr_pkg::OFF_START, 32'h0);
      wr(adcr_pkg::OFF_MODE, 32'h2);
      snap = starts;
      wr(adcr_pkg::OFF_START, 32'h1);
      repeat (60) @(negedge core_clk);
      chk(32'(starts - snap >= 3), 32'h1, "free run");
      wr(adcr_pkg::OFF_START, 32'h0);
      repeat (20) @(negedge core_clk);
      snap = starts;
      repeat (40) @(negedge core_clk);
      chk(32'(starts), 32'(snap), "free stop");
      wr(adcr_pkg::OFF_MODE, 32'h0);
      // DMA run stops at the programmed count
      wr(adcr_pkg::OFF_CNT, 32'h3);
      wr(adcr_pkg::OFF_MODE, 32'h4);
      dma_base = dones;
      dma_n = 0;
      snap = starts;
      wr(adcr_pkg::OFF_START, 32'h1);
      wait_cnt(dma_n, 3);
      repeat (60) @(negedge core_clk);
      chk(32'(starts - snap), 32'h3, "dma starts");
      chk(32'(dma_n), 32'h3, "dma words");
      wr(adcr_pkg::OFF_MODE, 32'h0);
      finish_test();
   end
endmodule // tb
`default_nettype wire
